// ### ebcn_map.svh
// Purpose: offsets, field positions, reset values and codes of the card/NAND glue
// Assumes: AXI4-Lite byte addressing, 32-bit words
// Notes: included by bare name
// How it works
// R1 - I/O mode drives card I/O strobes only
// R2 - memory modes drive card memory strobes only
// R3 - byte lane enables decoded per access size
// R4 - odd byte on low lane needs 8-bit
// R5 - card enables follow card select waveform
// R6 - card enable moves selects 4-6 to card
// R7 - shared strobe and A25 pins carry card signals
// R8 - buffer enable timed as card select
// R9 - buffer direction held across transfer
// R10 - software picks card mode by setup/hold
// R11 - NAND support on 0x4 window
// R12 - NAND strobes only inside NAND window
// R13 - NAND enable muxes pins and pad direction
// R14 - software separates NAND cycles by offset
// R15 - NAND chip enable kept via GPIO
// R16 - bit0 routes select 0 to burst controller
// R17 - address bit 23 selects I/O mode
// R18 - bit1 routes select 1 to dynamic controller
// R19 - bit3 turns on NAND logic
// R20 - bit4 turns on card logic
// R21 - unused bits zero, fields reset zero
`ifndef EBCN_MAP_SVH
`define EBCN_MAP_SVH
`define EBCN_AW 8
`define EBCN_OFS_CSA 8'h00
`define EBCN_OFS_CFG 8'h04
`define EBCN_CSA_BANK0 0
`define EBCN_CSA_BANK1 1
`define EBCN_CSA_NAND 3
`define EBCN_CSA_CARD 4
`define EBCN_CFG_PUOFF 0
`define EBCN_RST_FIELD 1'b0
`define EBCN_NAND_TOP 4'h4
`define EBCN_IO_SEL_BIT 23
`define EBCN_RESP_OKAY 2'h0
`define EBCN_RESP_SLVERR 2'h2
`endif

// ### ebcn_pkg.sv
// Purpose: types of the card/NAND glue
// Assumes: constants come from ebcn_map.svh
// Notes: one packed struct holds all state
`include "ebcn_map.svh"
package ebcn_pkg;
  typedef struct packed {
    logic                 awready;
    logic                 wready;
    logic                 arready;
    logic                 aw_have;
    logic [`EBCN_AW-1:0]  aw_addr;
    logic                 w_have;
    logic [31:0]          w_data;
    logic [3:0]           w_strb;
    logic                 bvalid;
    logic [1:0]           bresp;
    logic                 rvalid;
    logic [31:0]          rdata;
    logic [1:0]           rresp;
    logic                 bank0_burst;
    logic                 bank1_dram;
    logic                 nand_en;
    logic                 card_en;
    logic                 pu_off;
    logic                 card_act;
    logic                 dir;
    logic [7:0]           cs_n;
    logic                 rd_n;
    logic                 wr0_n;
    logic                 wr1_n;
    logic                 wr3_n;
    logic                 a25;
    logic                 rdy_o;
    logic                 rdy_oe_n;
    logic                 baa;
    logic                 rdy_in;
  } ebcn_state_t;
endpackage

// ### ebcn_glue.sv
// Purpose: card and NAND glue plus chip select assignment of the external bus
// Assumes: all inputs synchronous to clk_sys; static controller strobes active low
// Notes: every pin output is registered, so pins lag their sources by one cycle
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/1ps
`include "ebcn_map.svh"
module ebcn_glue (
  input  wire logic        clk_sys,
  input  wire logic        nrst,
  input  wire logic        ce,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic [2:0]  s_axi_awprot,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic [2:0]  s_axi_arprot,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  input  wire logic [7:0]  stat_cs_n,
  input  wire logic        stat_rd_n,
  input  wire logic        stat_wr0_n,
  input  wire logic        stat_wr1_n,
  input  wire logic        stat_wr3_n,
  input  wire logic        stat_a25,
  input  wire logic [31:0] xfer_addr,
  input  wire logic        xfer_write,
  input  wire logic        xfer_half,
  input  wire logic        card_bus8,
  input  wire logic        bfc_cs0_n,
  input  wire logic        sdram_cs1_n,
  input  wire logic        burst_advance_ack,
  input  wire logic        pin_rdy_i,
  output logic [7:0]       pin_cs_n,
  output logic             pin_rd_n,
  output logic             pin_wr0_n,
  output logic             pin_wr1_n,
  output logic             pin_wr3_n,
  output logic             pin_a25,
  output logic             pin_rdy_o,
  output logic             pin_rdy_oe_n,
  output logic             pin_baa_wr,
  output logic             burst_ready_in,
  output logic             pullup_disable
);

  ebcn_pkg::ebcn_state_t q;
  ebcn_pkg::ebcn_state_t s;

  logic card_acc;
  logic io_mode;
  logic nand_acc;
  logic ce_low_n;
  logic ce_high_n;
  logic dir_d;
  logic [7:0] cs_mux_n;

  // byte offsets of the two registers
  localparam logic [7:0] OFS_CSA = `EBCN_OFS_CSA;
  localparam logic [7:0] OFS_CFG = `EBCN_OFS_CFG;

  // card side decode
  always_comb
  begin
    card_acc = q.card_en & ~stat_cs_n[4];
    io_mode  = xfer_addr[`EBCN_IO_SEL_BIT]; // [R17]
    nand_acc = q.nand_en & ~stat_cs_n[3]
             & (xfer_addr[31:28] == `EBCN_NAND_TOP); // [R11] [R12]
    // byte lanes; idle high like the card select [R5]
    if (!card_acc)
    begin
      ce_high_n = 1'b1;
      ce_low_n  = 1'b1;
    end
    else if (xfer_half)
    begin
      ce_high_n = 1'b0; // [R3]
      ce_low_n  = 1'b0;
    end
    else if (card_bus8 || !xfer_addr[0])
    begin
      ce_high_n = 1'b1; // [R3] [R4]
      ce_low_n  = 1'b0;
    end
    else
    begin
      ce_high_n = 1'b0; // [R3] [R4]
      ce_low_n  = 1'b1;
    end
    // direction captured at transfer start, then frozen [R9]
    if (card_acc && !q.card_act)
      dir_d = ~xfer_write;
    else
      dir_d = q.dir;
    // select routing
    cs_mux_n    = stat_cs_n;
    cs_mux_n[0] = q.bank0_burst ? bfc_cs0_n : stat_cs_n[0]; // [R16]
    cs_mux_n[1] = q.bank1_dram ? sdram_cs1_n : stat_cs_n[1]; // [R18]
    if (q.card_en) // [R20]
    begin
      cs_mux_n[4] = stat_cs_n[4]; // [R6] [R8]
      cs_mux_n[5] = ce_low_n; // [R6] [R5]
      cs_mux_n[6] = ce_high_n; // [R6] [R5]
    end
  end

  // next state
  always_comb
  begin
    s = q;
    // pin multiplexing
    s.card_act = card_acc;
    s.dir      = dir_d;
    s.cs_n     = cs_mux_n;
    if (card_acc)
    begin
      s.rd_n  = io_mode ? 1'b1 : stat_rd_n; // [R1] [R2] [R7]
      s.wr0_n = io_mode ? 1'b1 : stat_wr0_n; // [R1] [R2] [R7]
      s.wr1_n = io_mode ? stat_rd_n : 1'b1; // [R1] [R2] [R7]
      s.wr3_n = io_mode ? stat_wr0_n : 1'b1; // [R1] [R2] [R7]
      s.a25   = dir_d; // [R7] [R9]
    end
    else
    begin
      s.rd_n  = stat_rd_n;
      s.wr0_n = stat_wr0_n;
      s.wr1_n = stat_wr1_n;
      s.wr3_n = stat_wr3_n;
      s.a25   = stat_a25;
    end
    // nand strobes or burst handshake on shared pads
    if (q.nand_en) // [R19]
    begin
      s.rdy_oe_n = 1'b0; // [R13]
      s.rdy_o    = nand_acc ? stat_rd_n : 1'b1; // [R12]
      s.baa      = nand_acc ? stat_wr0_n : 1'b1; // [R12] [R13]
      s.rdy_in   = 1'b0;
    end
    else
    begin
      s.rdy_oe_n = 1'b1; // [R13]
      s.rdy_o    = 1'b1;
      s.baa      = burst_advance_ack; // [R13]
      s.rdy_in   = pin_rdy_i;
    end
    // write channel
    if (q.bvalid && s_axi_bready)
      s.bvalid = 1'b0;
    if (q.awready && s_axi_awvalid)
    begin
      s.aw_have = 1'b1;
      s.aw_addr = s_axi_awaddr;
    end
    if (q.wready && s_axi_wvalid)
    begin
      s.w_have = 1'b1;
      s.w_data = s_axi_wdata;
      s.w_strb = s_axi_wstrb;
    end
    if (s.aw_have && s.w_have && !s.bvalid)
    begin
      s.aw_have = 1'b0;
      s.w_have  = 1'b0;
      s.bvalid  = 1'b1;
      s.bresp   = `EBCN_RESP_OKAY;
      if (s.aw_addr[7:2] == OFS_CSA[7:2])
      begin
        if (s.w_strb[0])
        begin
          s.bank0_burst = s.w_data[`EBCN_CSA_BANK0]; // [R16] [R21]
          s.bank1_dram  = s.w_data[`EBCN_CSA_BANK1]; // [R18]
          s.nand_en     = s.w_data[`EBCN_CSA_NAND]; // [R19]
          s.card_en     = s.w_data[`EBCN_CSA_CARD]; // [R20]
        end
      end
      else if (s.aw_addr[7:2] == OFS_CFG[7:2])
      begin
        if (s.w_strb[0])
          s.pu_off = s.w_data[`EBCN_CFG_PUOFF];
      end
      else
        s.bresp = `EBCN_RESP_SLVERR;
    end
    s.awready = ~s.aw_have & ~s.bvalid;
    s.wready  = ~s.w_have & ~s.bvalid;
    // read channel
    if (q.rvalid && s_axi_rready)
      s.rvalid = 1'b0;
    if (q.arready && s_axi_arvalid)
    begin
      s.rvalid = 1'b1;
      s.rdata  = 32'h0000_0000; // [R21]
      s.rresp  = `EBCN_RESP_OKAY;
      if (s_axi_araddr[7:2] == OFS_CSA[7:2])
      begin
        s.rdata[`EBCN_CSA_BANK0] = q.bank0_burst;
        s.rdata[`EBCN_CSA_BANK1] = q.bank1_dram;
        s.rdata[`EBCN_CSA_NAND]  = q.nand_en;
        s.rdata[`EBCN_CSA_CARD]  = q.card_en;
      end
      else if (s_axi_araddr[7:2] == OFS_CFG[7:2])
        s.rdata[`EBCN_CFG_PUOFF] = q.pu_off;
      else
        s.rresp = `EBCN_RESP_SLVERR;
    end
    s.arready = ~s.rvalid;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      q          <= '0;
      q.awready  <= 1'b1;
      q.wready   <= 1'b1;
      q.arready  <= 1'b1;
      q.bank0_burst <= `EBCN_RST_FIELD; // [R21]
      q.bank1_dram  <= `EBCN_RST_FIELD;
      q.nand_en     <= `EBCN_RST_FIELD;
      q.card_en     <= `EBCN_RST_FIELD;
      q.pu_off   <= `EBCN_RST_FIELD;
      q.cs_n     <= 8'hff;
      q.rd_n     <= 1'b1;
      q.wr0_n    <= 1'b1;
      q.wr1_n    <= 1'b1;
      q.wr3_n    <= 1'b1;
      q.rdy_o    <= 1'b1;
      q.rdy_oe_n <= 1'b1;
      q.baa      <= 1'b1;
    end
    else if (ce)
      q <= s;
  end

  assign s_axi_awready  = q.awready;
  assign s_axi_wready   = q.wready;
  assign s_axi_bvalid   = q.bvalid;
  assign s_axi_bresp    = q.bresp;
  assign s_axi_arready  = q.arready;
  assign s_axi_rvalid   = q.rvalid;
  assign s_axi_rdata    = q.rdata;
  assign s_axi_rresp    = q.rresp;
  assign pin_cs_n       = q.cs_n;
  assign pin_rd_n       = q.rd_n;
  assign pin_wr0_n      = q.wr0_n;
  assign pin_wr1_n      = q.wr1_n;
  assign pin_wr3_n      = q.wr3_n;
  assign pin_a25        = q.a25;
  assign pin_rdy_o      = q.rdy_o;
  assign pin_rdy_oe_n   = q.rdy_oe_n;
  assign pin_baa_wr     = q.baa;
  assign burst_ready_in = q.rdy_in;
  assign pullup_disable = q.pu_off;

endmodule

// ### ebcn_props.sv
// Purpose: port assertions of the card/NAND glue
// Assumes: bound to ebcn_glue, ce held high
// Notes: pins lag their sources by one cycle
`timescale 1ns/1ps
module ebcn_props (
  input wire logic        clk_sys,
  input wire logic        nrst,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [7:0]  stat_cs_n,
  input wire logic [31:0] xfer_addr,
  input wire logic [7:0]  pin_cs_n,
  input wire logic        pin_rdy_o,
  input wire logic        pin_rdy_oe_n,
  input wire logic        pin_baa_wr,
  input wire logic        burst_ready_in
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read unanswered");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped");
  a_ar_excl: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("arready with rvalid");
  a_buf_en: assert property (pin_cs_n[4] == $past(stat_cs_n[4]))
    else $error("buffer enable off card select");
  a_card_idle: assert property (&stat_cs_n[6:4] |=> &pin_cs_n[6:4])
    else $error("card enable without select");
  a_nand_gate: assert property (!pin_rdy_oe_n && $past(!pin_rdy_oe_n && xfer_addr[31:28] != 4'h4)
    |-> pin_rdy_o && pin_baa_wr)
    else $error("nand strobe outside window");
  a_pad_dir: assert property (pin_rdy_oe_n ? pin_rdy_o : !burst_ready_in)
    else $error("ready pad mux wrong");
  c_card: cover property (!pin_cs_n[4] && !pin_cs_n[6]);
  c_nand: cover property (!pin_rdy_oe_n && !pin_rdy_o);
  c_read: cover property (s_axi_rvalid && s_axi_rready);
endmodule

bind ebcn_glue ebcn_props chk_u (.*);

// ### ebcn_slot_model.sv
// Purpose: far side of the ready pad
// Assumes: pad is input to the glue unless its enable is low
// Notes: idle answer alternates each cycle
`timescale 1ns/1ps
module ebcn_slot_model (
  input  wire logic clk_sys,
  input  wire logic pin_rdy_o,
  input  wire logic pin_rdy_oe_n,
  output logic      pad
);
  logic drv_q = 1'b0;
  // a stale copy never matches a toggling answer
  always @(posedge clk_sys) drv_q <= ~drv_q;
  assign pad = pin_rdy_oe_n ? drv_q : pin_rdy_o;
endmodule

// ### ebcn_glue_tb.sv
// Purpose: self-checking bench of the card/NAND glue
// Assumes: ce held high
// Notes: expected results queued, popped by monitors
`timescale 1ns/1ps
module ebcn_glue_tb;
  logic        clk_sys, nrst, ce, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready, stat_rd_n, stat_wr0_n;
  logic        stat_wr1_n, stat_wr3_n, stat_a25, xfer_write, xfer_half, card_bus8, bfc_cs0_n, sdram_cs1_n;
  logic        burst_advance_ack, pin_rdy_i, pin_rd_n, pin_wr0_n, pin_wr1_n, pin_wr3_n, pin_a25, pin_rdy_o;
  logic        pin_rdy_oe_n, pin_baa_wr, burst_ready_in, pullup_disable;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [2:0]  s_axi_awprot, s_axi_arprot;
  logic [3:0]  s_axi_wstrb;
  logic [4:0]  m;
  logic [7:0]  s_axi_awaddr, s_axi_araddr, stat_cs_n, pin_cs_n;
  logic [31:0] s_axi_wdata, s_axi_rdata, xfer_addr;
  logic [33:0] bus_q[$];
  logic [16:0] pin_q[$];
  integer      err_total = 0, n_tests = 0, seed = 28;

  ebcn_glue dut_u (.*);
  ebcn_slot_model slot_u (.clk_sys, .pin_rdy_o, .pin_rdy_oe_n, .pad(pin_rdy_i));

  initial
  begin
    clk_sys = 1'b0;
    forever #4 clk_sys = ~clk_sys;
  end

  task chk_bus(input logic [33:0] e, input logic [33:0] g);
    n_tests++;
    if (g !== e)
    begin
      err_total++;
      $display("ERROR t=%0t exp=%h got=%h", $time, e, g);
    end
  endtask

  task chk_pin(input logic [16:0] e, input logic [16:0] g);
    chk_bus({17'h0, e}, {17'h0, g});
  endtask

  task wrap_up;
    $display("checks=%0d errors=%0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task wr(input logic [7:0] a, input logic [31:0] d);
    bus_q.push_back(34'h0);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_awready) s_axi_awvalid <= 1'b0;
      if (s_axi_wready) s_axi_wvalid <= 1'b0;
      if (s_axi_bvalid) s_axi_bready <= 1'b0;
    end while (s_axi_bready);
  endtask

  task rd(input logic [7:0] a, input logic [33:0] e);
    bus_q.push_back(e);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    do
    begin
      @(posedge clk_sys);
      if (s_axi_arready) s_axi_arvalid <= 1'b0;
      if (s_axi_rvalid) s_axi_rready <= 1'b0;
    end while (s_axi_rready);
  endtask

  function logic [16:0] ep(input logic dir);
    logic [7:0] c;
    logic       card, io, win;
    c = stat_cs_n;
    card = m[4] && !c[4];
    io = xfer_addr[23];
    win = (xfer_addr[31:28] == 4'h4) && !c[3];
    ep[16] = !m[3] && pin_rdy_i;
    if (m[0]) c[0] = bfc_cs0_n;
    if (m[1]) c[1] = sdram_cs1_n;
    if (m[4]) c[6:5] = {!card | (!xfer_half & (card_bus8 | !xfer_addr[0])),
                        !card | (!xfer_half & !card_bus8 & xfer_addr[0])};
    ep[15:3] = card ? {c, io | stat_rd_n, io | stat_wr0_n, !io | stat_rd_n, !io | stat_wr0_n, dir}
                    : {c, stat_rd_n, stat_wr0_n, stat_wr1_n, stat_wr3_n, stat_a25};
    ep[2:0] = m[3] ? {stat_rd_n | !win, 1'b0, stat_wr0_n | !win} : {2'b11, burst_advance_ack};
  endfunction

  // cycle-by-cycle random pin traffic, last cycle idle
  task burst(input logic [3:0] top, input int n);
    logic [31:0] r, c;
    logic        dir;
    for (int i = 0; i <= n; i++)
    begin
      r = $random(seed);
      c = $random(seed);
      if (i == 0) dir = !r[10];
      xfer_addr <= {top, r[27:0]};
      xfer_write <= r[10];
      {stat_rd_n, stat_wr0_n, stat_wr1_n, stat_wr3_n, stat_a25, xfer_half, card_bus8, bfc_cs0_n, sdram_cs1_n,
       burst_advance_ack} <= c[9:0];
      stat_cs_n <= (i == n) ? 8'hFF : {c[15:13], top != 4'h5, top != 4'h4, c[12:10]};
      @(posedge clk_sys);
      pin_q.push_back(ep(dir));
    end
  endtask

  always @(posedge clk_sys)
  begin
    if (s_axi_bvalid && s_axi_bready) chk_bus(bus_q.pop_front(), {s_axi_bresp, 32'h0});
    if (s_axi_rvalid && s_axi_rready) chk_bus(bus_q.pop_front(), {s_axi_rresp, s_axi_rdata});
  end

  always @(negedge clk_sys)
    if (pin_q.size() > 0)
      chk_pin(pin_q.pop_front(), {burst_ready_in, pin_cs_n, pin_rd_n, pin_wr0_n, pin_wr1_n, pin_wr3_n, pin_a25, pin_rdy_o,
                                  pin_rdy_oe_n, pin_baa_wr});

  initial
  begin
    #100000;
    err_total++;
    wrap_up;
  end

  initial
  begin
    {nrst, ce, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 7'b0100000;
    {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot, s_axi_wdata, xfer_addr, m} = '0;
    {stat_rd_n, stat_wr0_n, stat_wr1_n, stat_wr3_n, stat_a25, xfer_write, xfer_half, card_bus8} = '1;
    {bfc_cs0_n, sdram_cs1_n, burst_advance_ack, stat_cs_n, s_axi_wstrb} = {11'h7FF, 4'h1};
    repeat (3) @(posedge clk_sys);
    nrst <= 1'b1;
    @(posedge clk_sys);
    rd(8'h00, 34'h0);
    rd(8'h08, {2'h2, 32'h0});
    wr(8'h00, 32'hFFFF_FFFF);
    rd(8'h00, 34'h1B);
    wr(8'h04, 32'h0000_0001);
    rd(8'h04, 34'h1);
    chk_bus(34'h1, {33'h0, pullup_disable});
    for (int k = 0; k < 32; k++)
    begin
      m = k[4:0] & 5'h1B;
      wr(8'h00, {27'h0, m});
      burst(4'h5, 3);
      burst(4'h4, 2);
      burst(k[3:0], 1);
    end
    wrap_up;
  end
endmodule
